// *** rtl/gdi_acceptor.sv ***
`timescale 1ns/1ps
`default_nettype none

module gdi_acceptor (
	input  wire logic       clk_in,
	input  wire logic       nrst_in,
	input  wire logic       act_in,
	input  wire logic       rdy_in,
	input  wire logic       dav_in,
	input  wire logic       eoi_in,
	input  wire logic [7:0] data_in,
	output logic            nrfd_out,
	output logic            ndac_out,
	output logic            got_out,
	output logic            eoi_out,
	output logic      [7:0] byte_out
);
	import gdi_pkg::*;

	gdi_acc_st_type s, n;

	// three-wire acceptor handshake
	always_comb begin
		n     = s;
		n.got = 1'b0;
		case (s.st)
		AC_OFF: begin
			if (act_in) begin
				n.nrfd = 1'b1;
				n.ndac = 1'b1;
				n.st   = AC_NRDY;
			end
		end
		AC_NRDY: begin
			if (rdy_in && !dav_in) begin
				n.nrfd = 1'b0;
				n.st   = AC_RDY;
			end
		end
		AC_RDY: begin
			if (dav_in) begin
				n.nrfd = 1'b1;
				n.ndac = 1'b0;
				n.byt  = data_in;
				n.eoi  = eoi_in;
				n.got  = 1'b1;
				n.st   = AC_TAKEN;
			end
		end
		AC_TAKEN: begin
			if (!dav_in) begin
				n.ndac = 1'b1;
				n.st   = AC_NRDY;
			end
		end
		default: n.st = AC_OFF;
		endcase
		// release both lines when not listening, except while DAV still holds a taken byte
		if (!act_in && (s.st != AC_TAKEN || !dav_in)) begin
			n.st   = AC_OFF;
			n.got  = 1'b0; // no capture report once released
			n.nrfd = 1'b0;
			n.ndac = 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in)
			s <= '0;
		else
			s <= n;
	end

	assign nrfd_out = s.nrfd;
	assign ndac_out = s.ndac;
	assign got_out  = s.got;
	assign eoi_out  = s.eoi;
	assign byte_out = s.byt;

endmodule // gdi_acceptor

`default_nettype wire

// *** rtl/gdi_defines.svh ***
`ifndef GDI_DEFINES_SVH
`define GDI_DEFINES_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define GDI_A_CTRL  8'h00
`define GDI_A_STAT  8'h04
`define GDI_A_RXD   8'h08
`define GDI_A_TXD   8'h0C
`define GDI_A_STB   8'h10

// ----------------------------------------
// field positions, reset value and word size code
// ----------------------------------------
`define GDI_CT_SRQ  5
`define GDI_ST_CLR  8
`define GDI_TX_EOI  8
`define GDI_RQS     6
`define GDI_PA_RST  5'h00
`define GDI_SZ_WORD 3'h2

// ----------------------------------------
// command codes, seven bits, and two-bit address groups
// ----------------------------------------
`define GDI_C_GTL   7'h01
`define GDI_C_SDC   7'h04
`define GDI_C_LLO   7'h11
`define GDI_C_DCL   7'h14
`define GDI_C_SPE   7'h18
`define GDI_C_SPD   7'h19
`define GDI_C_UNL   7'h3F
`define GDI_C_UNT   7'h5F
`define GDI_LAG     2'h1
`define GDI_TAG     2'h2

`endif

// *** rtl/gdi_pkg.sv ***
package gdi_pkg;

	typedef enum logic [1:0] {AC_OFF, AC_NRDY, AC_RDY, AC_TAKEN} gdi_acc_type;
	typedef enum logic [1:0] {SR_IDLE, SR_LOAD, SR_WAIT, SR_DAV} gdi_src_type;

	// acceptor state
	typedef struct packed {
		gdi_acc_type st;
		logic        nrfd;
		logic        ndac;
		logic        got;
		logic        eoi;
		logic [7:0]  byt;
	} gdi_acc_st_type;

	// interface state
	typedef struct packed {
		logic        hready;
		logic        dp_wr;
		logic [7:0]  dp_addr;
		logic [31:0] hrdata;
		logic [4:0]  pa;
		logic        srq_req;
		logic [7:0]  stb;
		logic        remote, lockout, spoll, lad, tad, clr, ren_d, panel_en;
		logic        rx_v;
		logic [7:0]  rx_byte;
		logic        rx_eoi;
		logic        tx_v;
		logic [7:0]  tx_byte;
		logic        tx_eoi;
		gdi_src_type src;
		logic        dav;
		logic [7:0]  dio_oe;
		logic        eoi_oe;
		logic        lo;
	} gdi_top_st_type;

endpackage

// *** rtl/gdi_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module gdi_sync #(
	parameter int W = 17
) (
	input  wire logic         clk_in,
	input  wire logic         nrst_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} gdi_sync_st_type;

	gdi_sync_st_type s, n;

	// two stages, first read only by second
	always_comb begin
		n    = s;
		n.s1 = d_in;
		n.s2 = s.s1;
	end

	// idle bus lines float high
	always_ff @(posedge clk_in) begin
		if (!nrst_in)
			s <= '1;
		else
			s <= n;
	end

	assign q_out = s.s2;

endmodule // gdi_sync

`default_nettype wire

// *** rtl/gdi_top.sv ***
// The placing of the registers and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "gdi_defines.svh"

// Contract
// - all bus lines low means true
// - bytes move over eight data lines
// - ATN true: command byte; false: data
// - sender marks last byte with EOI
// - hold SRQ until serviced by poll
// - REN true moves device toward remote
// - IFC idles talker and listener
// - source drives DAV, acceptor NRFD/NDAC
// - source asserts DAV after NRFD high, NDAC low
// - on DAV pull NRFD, then release NDAC; the acceptor does both on the same clock edge
// - NDAC high only after all accepted
// - one handshake for every byte kind
// - commands with ATN, strings as data
// - universal commands act without addressing
// - lockout disables front-panel local key
// - device clear returns default state
// - poll enable enters, disable leaves mode
// - selective clear when listen-addressed
// - go-to-local when addressed leaves remote
// - unlisten and untalk idle the functions
// - listen address is primary OR 20
// - talk address is primary OR 40
// - addressed commands need prior listen address

module gdi_top (
	input  wire logic        CLK_IN,
	input  wire logic        NRST_IN,
	input  wire logic        HSEL_IN,
	input  wire logic [31:0] HADDR_IN,
	input  wire logic [1:0]  HTRANS_IN,
	input  wire logic        HWRITE_IN,
	input  wire logic [2:0]  HSIZE_IN,
	input  wire logic [31:0] HWDATA_IN,
	input  wire logic        HREADY_IN,
	output logic      [31:0] HRDATA_OUT,
	output logic             HREADYOUT_OUT,
	output logic             HRESP_OUT,
	input  wire logic [7:0]  DIO_N_IN,
	output logic      [7:0]  DIO_N_OUT,
	output logic      [7:0]  DIO_OE_OUT,
	input  wire logic        ATN_N_IN,
	input  wire logic        IFC_N_IN,
	input  wire logic        REN_N_IN,
	input  wire logic        EOI_N_IN,
	output logic             EOI_N_OUT,
	output logic             EOI_OE_OUT,
	input  wire logic        SRQ_N_IN,
	output logic             SRQ_N_OUT,
	output logic             SRQ_OE_OUT,
	input  wire logic        DAV_N_IN,
	output logic             DAV_N_OUT,
	output logic             DAV_OE_OUT,
	input  wire logic        NRFD_N_IN,
	output logic             NRFD_N_OUT,
	output logic             NRFD_OE_OUT,
	input  wire logic        NDAC_N_IN,
	output logic             NDAC_N_OUT,
	output logic             NDAC_OE_OUT,
	input  wire logic        LOCAL_KEY_IN,
	output logic             PANEL_EN_OUT
);
	import gdi_pkg::*;

	// ----------------------------------------
	// pin synchronisers and true levels
	// ----------------------------------------
	gdi_top_st_type s, n;
	logic [16:0] pins_q;
	logic [7:0]  dio_t;
	logic        atn_t, ifc_t, ren_t, eoi_t, srq_t, dav_t, nrfd_t, ndac_t;
	logic        key_t;

	gdi_sync #(.W(17)) u_sync (
		.clk_in  (CLK_IN),
		.nrst_in (NRST_IN),
		.d_in    ({LOCAL_KEY_IN, SRQ_N_IN, NDAC_N_IN, NRFD_N_IN, DAV_N_IN,
		            EOI_N_IN, REN_N_IN, IFC_N_IN, ATN_N_IN, DIO_N_IN}),
		.q_out   (pins_q)
	);

	// low level on a bus line means true; the local key input is high true
	assign key_t = pins_q[16];
	assign {srq_t, ndac_t, nrfd_t, dav_t, eoi_t, ren_t, ifc_t, atn_t} =
		~pins_q[15:8];
	assign dio_t = ~pins_q[7:0];

	// ----------------------------------------
	// acceptor handshake
	// ----------------------------------------
	logic       acc_act, acc_rdy, acc_nrfd, acc_ndac, acc_got, acc_eoi;
	logic [7:0] acc_byte;
	logic [6:0] cmd;
	logic       cmd_got, dat_got, clr_ev, talk_ok, src_ok;
	logic [7:0] src_byte;

	// commands taken unless IFC is true; data only when addressed with room
	assign acc_act = (atn_t | s.lad) & ~ifc_t;
	assign acc_rdy = atn_t | ~s.rx_v;

	gdi_acceptor u_acc (
		.clk_in   (CLK_IN),
		.nrst_in  (NRST_IN),
		.act_in   (acc_act),
		.rdy_in   (acc_rdy),
		.dav_in   (dav_t),
		.eoi_in   (eoi_t),
		.data_in  (dio_t),
		.nrfd_out (acc_nrfd),
		.ndac_out (acc_ndac),
		.got_out  (acc_got),
		.eoi_out  (acc_eoi),
		.byte_out (acc_byte)
	);

	// byte kind chosen by attention
	assign cmd     = acc_byte[6:0];
	assign cmd_got = acc_got & atn_t;
	assign dat_got = acc_got & ~atn_t & s.lad;
	assign clr_ev  = cmd_got & ((cmd == `GDI_C_DCL) |
		((cmd == `GDI_C_SDC) & s.lad));

	// source side conditions
	assign talk_ok  = s.tad & ~atn_t & ~ifc_t;
	assign src_ok   = ~nrfd_t & ndac_t;
	assign src_byte = s.spoll ? {s.stb[7], s.srq_req, s.stb[5:0]} : s.tx_byte;

	// ----------------------------------------
	// register read mux
	// ----------------------------------------
	function automatic logic [31:0] gdi_rd(input logic [7:0] a,
		input gdi_top_st_type t);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (a)
		`GDI_A_CTRL: r[5:0] = {t.srq_req, t.pa};
		`GDI_A_STAT: r[9:0] = {t.ren_d, t.clr, ~t.tx_v, t.rx_v, t.srq_req,
			t.tad, t.lad, t.spoll, t.lockout, t.remote};
		`GDI_A_RXD:  r[8:0] = {t.rx_eoi, t.rx_byte};
		`GDI_A_TXD:  r[8:0] = {t.tx_eoi, t.tx_byte};
		`GDI_A_STB:  r[7:0] = t.stb;
		default:     r = 32'h0000_0000;
		endcase
		return r;
	endfunction

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		n        = s;
		n.hready = 1'b1;
		n.dp_wr  = 1'b0;
		n.lo     = 1'b0;
		n.ren_d  = ren_t;

		// ahb address phase, read pops receive byte
		if (HSEL_IN && HTRANS_IN[1] && HREADY_IN) begin
			n.dp_wr   = HWRITE_IN & (HSIZE_IN == `GDI_SZ_WORD);
			n.dp_addr = HADDR_IN[7:0];
			n.hrdata  = HWRITE_IN ? 32'h0000_0000 : gdi_rd(HADDR_IN[7:0], s);
			if (!HWRITE_IN && HADDR_IN[7:0] == `GDI_A_RXD)
				n.rx_v = 1'b0;
		end

		// remote enable and panel key
		if (ren_t && !s.ren_d)
			n.remote = 1'b1;
		if (key_t && !s.lockout)
			n.remote = 1'b0;

		// multiline command decode
		if (cmd_got) begin
			case (cmd)
			`GDI_C_LLO: n.lockout = ren_t;
			`GDI_C_SPE: n.spoll = 1'b1;
			`GDI_C_SPD: n.spoll = 1'b0;
			`GDI_C_UNL: n.lad = 1'b0;
			`GDI_C_UNT: n.tad = 1'b0;
			`GDI_C_GTL: begin
				if (s.lad)
					n.remote = 1'b0;
			end
			default: begin
				if (cmd == {`GDI_LAG, s.pa})
					n.lad = 1'b1;
				if (cmd[6:5] == `GDI_TAG) begin
					n.tad = (cmd[4:0] == s.pa);
					if (cmd[4:0] == s.pa)
						n.lad = 1'b0;
				end
			end
			endcase
		end

		// device clear to default
		if (clr_ev) begin
			n.clr     = 1'b1;
			n.rx_v    = 1'b0;
			n.tx_v    = 1'b0;
			n.srq_req = 1'b0;
		end

		// data byte with end marker
		if (dat_got) begin
			n.rx_v    = 1'b1;
			n.rx_byte = acc_byte;
			n.rx_eoi  = acc_eoi;
		end

		// remote enable false forces local
		if (!ren_t) begin
			n.remote  = 1'b0;
			n.lockout = 1'b0;
		end

		// interface clear
		if (ifc_t) begin
			n.lad   = 1'b0;
			n.tad   = 1'b0;
			n.spoll = 1'b0;
		end

		// source handshake, drives DIO, EOI and DAV
		case (s.src)
		SR_IDLE: begin
			if (talk_ok && (s.spoll || s.tx_v)) begin
				n.dio_oe = src_byte;
				n.eoi_oe = ~s.spoll & s.tx_eoi;
				n.src    = SR_LOAD;
			end
		end
		SR_LOAD: n.src = SR_WAIT;
		SR_WAIT: begin
			if (src_ok) begin
				n.dav = 1'b1;
				n.src = SR_DAV;
			end
		end
		SR_DAV: begin
			if (!ndac_t) begin
				n.dav    = 1'b0;
				n.dio_oe = 8'h00;
				n.eoi_oe = 1'b0;
				n.src    = SR_IDLE;
				if (!s.spoll)
					n.tx_v = 1'b0;
				else if (s.dio_oe[`GDI_RQS])
					n.srq_req = 1'b0;
			end
		end
		default: n.src = SR_IDLE;
		endcase

		// attention or unaddressing aborts the source
		if (!talk_ok) begin
			n.src    = SR_IDLE;
			n.dav    = 1'b0;
			n.dio_oe = 8'h00;
			n.eoi_oe = 1'b0;
		end

		// ahb data phase writes
		if (s.dp_wr) begin
			case (s.dp_addr)
			`GDI_A_CTRL: begin
				n.pa = HWDATA_IN[4:0];
				if (HWDATA_IN[`GDI_CT_SRQ])
					n.srq_req = 1'b1;
			end
			`GDI_A_STAT: begin
				if (HWDATA_IN[`GDI_ST_CLR] && !clr_ev)
					n.clr = 1'b0;
			end
			`GDI_A_TXD: begin
				if (!n.tx_v) begin
					n.tx_v    = 1'b1;
					n.tx_byte = HWDATA_IN[7:0];
					n.tx_eoi  = HWDATA_IN[`GDI_TX_EOI];
				end
			end
			`GDI_A_STB: n.stb = HWDATA_IN[7:0];
			default: n.stb = s.stb;
			endcase
		end

		n.panel_en = ~n.remote;
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge CLK_IN) begin
		if (!NRST_IN) begin
			s          <= '0;
			s.hready   <= 1'b1;
			s.panel_en <= 1'b1;
			s.pa       <= `GDI_PA_RST;
		end else begin
			s <= n;
		end
	end

	// outputs, open-drain lines drive low when enabled
	assign HRDATA_OUT    = s.hrdata;
	assign HREADYOUT_OUT = s.hready;
	assign HRESP_OUT     = s.lo;
	assign DIO_N_OUT     = {8{s.lo}};
	assign DIO_OE_OUT    = s.dio_oe;
	assign EOI_N_OUT     = s.lo;
	assign EOI_OE_OUT    = s.eoi_oe;
	assign SRQ_N_OUT     = s.lo;
	assign SRQ_OE_OUT    = s.srq_req;
	assign DAV_N_OUT     = s.lo;
	assign DAV_OE_OUT    = s.dav;
	assign NRFD_N_OUT    = s.lo;
	assign NRFD_OE_OUT   = acc_nrfd;
	assign NDAC_N_OUT    = s.lo;
	assign NDAC_OE_OUT   = acc_ndac;
	assign PANEL_EN_OUT  = s.panel_en;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!NRST_IN);

	sequence s_byte_taken;
		acc_got;
	endsequence

	sequence s_dav_drop;
		NRFD_OE_OUT && !NDAC_OE_OUT && !dav_t && acc_act;
	endsequence

	chk_dav_gated: assert property (
		$rose(DAV_OE_OUT) |-> $past(src_ok) && $stable(DIO_OE_OUT))
		else $error("DAV asserted before ready");

	chk_dav_release: assert property (
		DAV_OE_OUT && !ndac_t && talk_ok |=> !DAV_OE_OUT && DIO_OE_OUT == 8'h00)
		else $error("DAV not released after accept");

	chk_atn_quiet: assert property (
		atn_t |=> !DAV_OE_OUT && !EOI_OE_OUT && DIO_OE_OUT == 8'h00)
		else $error("source active during attention");

	chk_ifc_idle: assert property (
		ifc_t |=> !s.lad && !s.tad && !s.spoll)
		else $error("interface clear ignored");

	chk_accept_order: assert property (
		s_byte_taken |-> NRFD_OE_OUT && !NDAC_OE_OUT)
		else $error("acceptor order wrong");

	chk_ndac_back: assert property (
		s_dav_drop |=> NDAC_OE_OUT ##1 (NRFD_OE_OUT || acc_rdy))
		else $error("NDAC not reasserted");

	chk_my_listen: assert property (
		cmd_got && cmd == {`GDI_LAG, s.pa} && !ifc_t && s.pa != 5'h1F |=> s.lad)
		else $error("listen address missed");

	chk_my_talk: assert property (
		cmd_got && cmd == {`GDI_TAG, s.pa} && !ifc_t && s.pa != 5'h1F |=> s.tad)
		else $error("talk address missed");

	chk_unlisten: assert property (
		cmd_got && cmd == `GDI_C_UNL |=> !s.lad)
		else $error("unlisten ignored");

	chk_gtl_unaddr: assert property (
		cmd_got && cmd == `GDI_C_GTL && !s.lad && s.remote && ren_t && !key_t
		|=> s.remote)
		else $error("unaddressed go-to-local obeyed");

	chk_key_locked: assert property (
		s.lockout && key_t && ren_t && s.remote && !cmd_got |=> s.remote)
		else $error("local key worked under lockout");

	chk_poll_enter: assert property (
		cmd_got && cmd == `GDI_C_SPE && !ifc_t |=> s.spoll)
		else $error("poll enable ignored");

	chk_srq_hold: assert property (
		SRQ_OE_OUT && !clr_ev && !(s.src == SR_DAV && s.spoll) |=> SRQ_OE_OUT)
		else $error("SRQ dropped before service");

	chk_rx_end: assert property (
		dat_got |=> s.rx_v && s.rx_eoi == $past(acc_eoi))
		else $error("end marker lost");

	chk_dev_clear: assert property (
		clr_ev |=> s.clr && !s.tx_v && !s.srq_req)
		else $error("device clear incomplete");

endmodule // gdi_top

`default_nettype wire

// *** sim/gdi_ctl_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// bus controller with a listener of its own
module gdi_ctl_model (
	input  wire logic       clk_in,
	input  wire logic [7:0] dio_n_in,
	input  wire logic       eoi_n_in,
	input  wire logic       dav_n_in,
	input  wire logic       nrfd_n_in,
	input  wire logic       ndac_n_in,
	output logic            atn_n_out,
	output logic            ifc_n_out,
	output logic            ren_n_out,
	output logic      [7:0] dio_oe_out,
	output logic            eoi_oe_out,
	output logic            dav_oe_out,
	output logic            nrfd_oe_out,
	output logic            ndac_oe_out
);
	// ----------------------------------------
	// idle: every line released
	// ----------------------------------------
	initial begin
		{atn_n_out, ifc_n_out, ren_n_out} = 3'h7;
		{dio_oe_out, eoi_oe_out, dav_oe_out} = 10'h000;
		{nrfd_oe_out, ndac_oe_out} = 2'h0;
	end

	// management lines, controller only
	task automatic mgmt(input logic ren, input logic ifc);
		@(posedge clk_in);
		ren_n_out <= ~ren;
		ifc_n_out <= ~ifc;
	endtask

	// line conditions waited on
	function automatic logic ok(input int k);
		case (k)
			0: return nrfd_n_in & ~ndac_n_in;
			1: return ndac_n_in;
			2: return ~dav_n_in;
			default: return dav_n_in;
		endcase
	endfunction

	// bounded wait, flags a hang
	task automatic wt(input int k, output logic to);
		int n;
		n = 0;
		while (ok(k) !== 1'b1 && n < 300) begin
			@(posedge clk_in);
			n++;
		end
		to = (n >= 300);
	endtask

	// source one byte, commands with atn true
	task automatic send(input logic [7:0] b, input logic atn,
		input logic eoi, output logic to);
		@(posedge clk_in);
		atn_n_out <= ~atn;
		dio_oe_out <= b;
		eoi_oe_out <= eoi;
		repeat (26) @(posedge clk_in);
		wt(0, to);
		if (!to) begin
			dav_oe_out <= 1'b1;
			@(posedge clk_in);
			wt(1, to);
		end
		dav_oe_out <= 1'b0;
		dio_oe_out <= 8'h00;
		eoi_oe_out <= 1'b0;
		repeat (4) @(posedge clk_in);
	endtask

	// accept one byte, slow sets the hold-off
	task automatic recv(input int slow, output logic [8:0] r,
		output logic to);
		@(posedge clk_in);
		atn_n_out <= 1'b1;
		ndac_oe_out <= 1'b1;
		nrfd_oe_out <= 1'b1;
		repeat (slow + 1) @(posedge clk_in);
		nrfd_oe_out <= 1'b0;
		wt(2, to);
		r = {~eoi_n_in, ~dio_n_in};
		nrfd_oe_out <= 1'b1;
		@(posedge clk_in);
		ndac_oe_out <= 1'b0;
		@(posedge clk_in);
		// a missing byte stays reported as a hang
		if (!to)
			wt(3, to);
		ndac_oe_out <= 1'b1;
		@(posedge clk_in);
		{nrfd_oe_out, ndac_oe_out} <= 2'h0;
	endtask
endmodule // gdi_ctl_model

`default_nettype wire

// *** sim/gpib_device_interface_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "gdi_defines.svh"

module gpib_device_interface_bench;
	logic        clk, rst_n, hsel, hwr, hrdy, hresp, key, panel, xndac;
	logic [1:0]  htr;
	logic [2:0]  hsz;
	logic [31:0] hadr, hwd, hrd;
	logic [7:0]  d_oe, c_dio, dio_n, dio_o;
	wire  [4:0]  ln_o;
	logic        e_oe, s_oe, v_oe, r_oe, a_oe, c_eoi, c_dav, c_rfd, c_dac;
	logic        atn_n, ifc_n, ren_n, eoi_n, dav_n, nrfd_n, ndac_n, srq_n;
	logic [8:0]  r;
	logic        to;
	int          error_cnt, checked;

	// wired-and of all drivers on each line
	assign dio_n = ~(d_oe | c_dio);
	assign eoi_n = ~(e_oe | c_eoi);
	assign dav_n = ~(v_oe | c_dav);
	assign nrfd_n = ~(r_oe | c_rfd);
	assign ndac_n = ~(a_oe | c_dac | xndac);
	assign srq_n = ~s_oe;
	always #2 clk = ~clk;

	gdi_top uut (.CLK_IN(clk), .NRST_IN(rst_n), .HSEL_IN(hsel),
		.HADDR_IN(hadr), .HTRANS_IN(htr), .HWRITE_IN(hwr), .HSIZE_IN(hsz),
		.HWDATA_IN(hwd), .HREADY_IN(hrdy), .HRDATA_OUT(hrd),
		.HREADYOUT_OUT(hrdy), .HRESP_OUT(hresp), .DIO_N_IN(dio_n),
		.DIO_N_OUT(dio_o), .DIO_OE_OUT(d_oe), .ATN_N_IN(atn_n),
		.IFC_N_IN(ifc_n), .REN_N_IN(ren_n), .EOI_N_IN(eoi_n),
		.EOI_N_OUT(ln_o[0]), .EOI_OE_OUT(e_oe), .SRQ_N_IN(srq_n),
		.SRQ_N_OUT(ln_o[1]), .SRQ_OE_OUT(s_oe), .DAV_N_IN(dav_n),
		.DAV_N_OUT(ln_o[2]), .DAV_OE_OUT(v_oe), .NRFD_N_IN(nrfd_n),
		.NRFD_N_OUT(ln_o[3]), .NRFD_OE_OUT(r_oe), .NDAC_N_IN(ndac_n),
		.NDAC_N_OUT(ln_o[4]),
		.NDAC_OE_OUT(a_oe), .LOCAL_KEY_IN(key), .PANEL_EN_OUT(panel));

	gdi_ctl_model ctl (.clk_in(clk), .dio_n_in(dio_n), .eoi_n_in(eoi_n),
		.dav_n_in(dav_n), .nrfd_n_in(nrfd_n), .ndac_n_in(ndac_n),
		.atn_n_out(atn_n), .ifc_n_out(ifc_n), .ren_n_out(ren_n),
		.dio_oe_out(c_dio), .eoi_oe_out(c_eoi), .dav_oe_out(c_dav),
		.nrfd_oe_out(c_rfd), .ndac_oe_out(c_dac));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic cmp(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	// bounded wait for hready at an edge
	task automatic hwait();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hrdy !== 1'b1 && n < 50);
		if (hrdy !== 1'b1) begin
			error_cnt++;
			tally_and_finish();
		end
	endtask

	// one single word transfer
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		hsel <= 1'b1;
		htr <= 2'h2;
		hadr <= {24'h00_0000, a};
		hwr <= w;
		hwait();
		htr <= 2'h0;
		hwd <= d;
		hwait();
		q = hrd;
		hsel <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e, input string nm);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		cmp(nm, e, q & m);
	endtask

	task automatic cmd(input logic [7:0] b);
		ctl.send(b, 1'b1, 1'b0, to);
		cmp("handshake", 32'h0, {31'h0, to});
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		rd(`GDI_A_STAT, 32'h0000_03FF, 32'h0000_0080, "stat");
		rd(`GDI_A_CTRL, 32'hFFFF_FFFF, 32'h0000_0000, "ctrl");
		rd(8'h14, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped");
		cmp("lines", 32'h0, {22'h0, d_oe, v_oe, e_oe});
		cmp("low levels", 32'h0, {18'h0, hresp, dio_o, ln_o});
	endtask

	task automatic t_remote();
		wr(`GDI_A_CTRL, 32'h0000_0005);
		ctl.mgmt(1'b1, 1'b0);
		repeat (6) @(posedge clk);
		rd(`GDI_A_STAT, 32'h0000_0201, 32'h0000_0201, "remote");
		cmd({1'b1, `GDI_LAG, 5'h05});
		cmd({1'b0, `GDI_C_LLO});
		rd(`GDI_A_STAT, 32'h0000_000B, 32'h0000_000B, "lock");
		cmp("panel", 32'h0, {31'h0, panel});
		key <= 1'b1;
		repeat (6) @(posedge clk);
		rd(`GDI_A_STAT, 32'h0000_0001, 32'h0000_0001, "key");
		key <= 1'b0;
		cmd({1'b0, `GDI_C_GTL});
		rd(`GDI_A_STAT, 32'h0000_0001, 32'h0000_0000, "gtl");
	endtask

	task automatic t_listen();
		ctl.send(8'h2A, 1'b0, 1'b1, to);
		cmp("data", 32'h0, {31'h0, to});
		rd(`GDI_A_RXD, 32'h0000_01FF, 32'h0000_012A, "rx");
		rd(`GDI_A_STAT, 32'h0000_0040, 32'h0000_0000, "pop");
		cmd({1'b0, `GDI_C_UNL});
		rd(`GDI_A_STAT, 32'h0000_0008, 32'h0000_0000, "unl");
		ctl.send(8'h52, 1'b0, 1'b0, to);
		cmp("refused", 32'h1, {31'h0, to});
		rd(`GDI_A_STAT, 32'h0000_0040, 32'h0000_0000, "no rx");
	endtask

	task automatic t_clear();
		cmd({1'b0, `GDI_C_SDC});
		rd(`GDI_A_STAT, 32'h0000_0100, 32'h0000_0000, "sdc");
		cmd({1'b0, `GDI_LAG, 5'h05});
		cmd({1'b0, `GDI_C_SDC});
		rd(`GDI_A_STAT, 32'h0000_0108, 32'h0000_0108, "sdc ad");
		wr(`GDI_A_STAT, 32'h0000_0100);
		cmd({1'b0, `GDI_C_UNL});
		cmd({1'b0, `GDI_C_DCL});
		rd(`GDI_A_STAT, 32'h0000_0108, 32'h0000_0100, "dcl");
	endtask

	// second listener holds ndac down
	task automatic t_talk();
		cmd({1'b0, `GDI_TAG, 5'h05});
		rd(`GDI_A_STAT, 32'h0000_0018, 32'h0000_0010, "mta");
		xndac <= 1'b1;
		wr(`GDI_A_TXD, 32'h0000_015A);
		fork
			ctl.recv(3, r, to);
			begin
				repeat (40) @(posedge clk);
				cmp("dav held", 32'h1, {31'h0, v_oe});
				xndac <= 1'b0;
			end
		join
		cmp("talk", 32'h0000_015A, {22'h0, to, r});
		rd(`GDI_A_STAT, 32'h0000_0080, 32'h0000_0080, "tx empty");
	endtask

	task automatic t_poll();
		wr(`GDI_A_STB, 32'h0000_0001);
		wr(`GDI_A_CTRL, 32'h0000_0025);
		repeat (3) @(posedge clk);
		cmp("srq on", 32'h0, {31'h0, srq_n});
		cmd({1'b0, `GDI_C_SPE});
		rd(`GDI_A_STAT, 32'h0000_0034, 32'h0000_0034, "spe");
		ctl.recv(1, r, to);
		cmp("stb", 32'h0000_0041, {23'h0, to, r[7:0]});
		repeat (4) @(posedge clk);
		cmp("srq off", 32'h1, {31'h0, srq_n});
		cmd({1'b0, `GDI_C_SPD});
		cmd({1'b0, `GDI_C_UNT});
		rd(`GDI_A_STAT, 32'h0000_0014, 32'h0000_0000, "spd");
	endtask

	task automatic t_ifc();
		cmd({1'b0, `GDI_LAG, 5'h05});
		ctl.mgmt(1'b1, 1'b1);
		repeat (6) @(posedge clk);
		ctl.mgmt(1'b0, 1'b0);
		repeat (4) @(posedge clk);
		rd(`GDI_A_STAT, 32'h0000_0219, 32'h0000_0000, "ifc");
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{clk, rst_n, hsel, hwr, key, xndac} = 6'h00;
		{htr, hsz, hadr, hwd} = {2'h0, 3'h2, 64'h0};
		error_cnt = 0;
		checked = 0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_remote();
		t_listen();
		t_clear();
		t_talk();
		t_poll();
		t_ifc();
		tally_and_finish();
	end
endmodule // gpib_device_interface_bench

`default_nettype wire
